// ==== src/rtcgt_top.sv ====
// Function
// (R1) Real-time counter: 32 bits, down, readable
// (R2) Counter write sets preset, read live
// (R3) Real-time scaler: 8 bits, down, readable
// (R4) Scaler write sets preset, read live
// (R5) Expiry after count times scaler-plus-one
// (R6) General counter: 32 bits, down, readable
// (R7) General counter write sets separate preset
// (R8) General scaler: 16 bits, down, readable
// (R9) General scaler write sets preset
// (R10) General expiry after count times scaler-plus-one
// (R11) Reload bit: restart or stop at zero
// (R12) Count-load bit copies preset, starts
// (R13) Enable bit runs or holds both
// (R14) Scaler-load bit copies preset, starts
// (R15) Expiry pulses interrupt request one cycle
// (R16) Unused scaler bits read zero, ignored
`timescale 1ns/1ps
`include "rtcgt_regs.svh"

module rtcgt_top
	import rtcgt_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Timer expiry requests
	output logic             rtcExpire,
	output logic             gpExpire,
	// Interrupt
	output logic             irq
);

	// ****************************************
	// Bus decode
	// ****************************************

	rtcgt_sel_t  setupSel;
	rtcgt_sel_t  accSel;
	wire logic   setupPh  = psel && !penable;
	wire logic   accDone  = psel && penable && pready;
	wire logic   wrDone   = accDone && pwrite;

	// No wait state on any access keeps the
	// answer independent of address and direction
	// Same decode serves the read and write paths
	assign setupSel = rtcgt_decode(paddr);
	assign accSel   = rtcgt_decode(paddr);

	wire logic   wrRtcCnt = wrDone && (accSel == SEL_RTC_CNT);
	wire logic   wrRtcScl = wrDone && (accSel == SEL_RTC_SCL);
	wire logic   wrGpCnt  = wrDone && (accSel == SEL_GP_CNT);
	wire logic   wrGpScl  = wrDone && (accSel == SEL_GP_SCL);
	wire logic   wrCtrl   = wrDone && (accSel == SEL_CTRL);
	wire logic   wrStat   = wrDone && (accSel == SEL_STAT);
	wire logic   wrMask   = wrDone && (accSel == SEL_MASK);

	// ****************************************
	// Control word fields
	// ****************************************

	// Named views of the written control word;
	// only meaningful while wrCtrl is high
	wire logic   ctlGpReload  = pwdata[`RTCGT_GP_RELOAD_B];
	wire logic   ctlGpCload   = pwdata[`RTCGT_GP_CLOAD_B];
	wire logic   ctlGpRun     = pwdata[`RTCGT_GP_RUN_B];
	wire logic   ctlGpSload   = pwdata[`RTCGT_GP_SLOAD_B];
	wire logic   ctlRtcReload = pwdata[`RTCGT_RTC_RELOAD_B];
	wire logic   ctlRtcCload  = pwdata[`RTCGT_RTC_CLOAD_B];
	wire logic   ctlRtcRun    = pwdata[`RTCGT_RTC_RUN_B];
	wire logic   ctlRtcSload  = pwdata[`RTCGT_RTC_SLOAD_B];

	// ****************************************
	// Preset and control registers
	// ****************************************

	logic [31:0] rtcCountPreset;
	logic [7:0]  rtcPrescalePreset;
	logic [31:0] gpCountPreset;
	logic [15:0] gpPrescalePreset;
	logic        rtcAutoReload;
	logic        rtcRunEnable;
	logic        gpAutoReload;
	logic        gpRunEnable;

	// Presets are write-only; reads see live state
	// Unmapped words never select, so writes drop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rtcCountPreset    <= `RTCGT_RTC_PRE_RST;
			rtcPrescalePreset <= `RTCGT_RTC_SCL_RST;
			gpCountPreset     <= `RTCGT_CNT_RST;
			gpPrescalePreset  <= `RTCGT_GP_SCL_RST;
		end else begin
			// R2 real-time counter preset
			if (wrRtcCnt) begin
				rtcCountPreset <= pwdata;
			end
			// R4 real-time scaler preset
			// R16 upper bits dropped
			if (wrRtcScl) begin
				rtcPrescalePreset <= pwdata[7:0];
			end
			// R7 general counter preset
			if (wrGpCnt) begin
				gpCountPreset <= pwdata;
			end
			// R9 general scaler preset
			if (wrGpScl) begin
				gpPrescalePreset <= pwdata[15:0];
			end
		end
	end

	// Level control bits of the control word
	// Reload and enable are levels; the load bits
	// below are one-shot strobes of the same write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rtcAutoReload <= 1'b1;
			rtcRunEnable  <= 1'b0;
			gpAutoReload  <= 1'b0;
			gpRunEnable   <= 1'b0;
		end else if (wrCtrl) begin
			// R11 reload selection
			rtcAutoReload <= ctlRtcReload;
			gpAutoReload  <= ctlGpReload;
			// R13 run or hold
			rtcRunEnable  <= ctlRtcRun;
			gpRunEnable   <= ctlGpRun;
		end
	end

	// ****************************************
	// Load strobes
	// ****************************************

	// R12 count-load on written one
	wire logic rtcCountLoad =
		wrCtrl && ctlRtcCload;
	wire logic gpCountLoad =
		wrCtrl && ctlGpCload;
	// R14 scaler-load on written one
	wire logic rtcPrescaleLoad =
		wrCtrl && ctlRtcSload;
	wire logic gpPrescaleLoad =
		wrCtrl && ctlGpSload;

	// ****************************************
	// Timers
	// ****************************************

	logic [31:0] rtcCount;
	logic [7:0]  rtcPrescale;
	logic [31:0] gpCount;
	logic [15:0] gpPrescale;
	logic        rtcExpireEv;
	logic        gpExpireEv;

	// Both timers share one body; only the scaler
	// width and its reset value differ. A counter
	// preset of zero behaves as one, so the shortest
	// period is a single scaler round.
	// R1 real-time counter
	// R3 real-time scaler
	rtcgt_timer #(
		.SW      (`RTCGT_RTC_SCL_W),
		.SCL_RST (`RTCGT_RTC_SCL_RST)
	) u_rtc (
		.clk            (clk),
		.rst_n          (rst_n),
		.runEnable      (rtcRunEnable),
		.autoReload     (rtcAutoReload),
		.countLoad      (rtcCountLoad),
		.prescaleLoad   (rtcPrescaleLoad),
		.countPreset    (rtcCountPreset),
		.prescalePreset (rtcPrescalePreset),
		.count          (rtcCount),
		.prescale       (rtcPrescale),
		.expire         (rtcExpireEv)
	);

	// R6 general counter
	// R8 general scaler
	rtcgt_timer #(
		.SW      (`RTCGT_GP_SCL_W),
		.SCL_RST (`RTCGT_GP_SCL_RST)
	) u_gp (
		.clk            (clk),
		.rst_n          (rst_n),
		.runEnable      (gpRunEnable),
		.autoReload     (gpAutoReload),
		.countLoad      (gpCountLoad),
		.prescaleLoad   (gpPrescaleLoad),
		.countPreset    (gpCountPreset),
		.prescalePreset (gpPrescalePreset),
		.count          (gpCount),
		.prescale       (gpPrescale),
		.expire         (gpExpireEv)
	);

	// ****************************************
	// Interrupt status and mask
	// ****************************************

	logic [1:0] intStatus;
	logic [1:0] intMask;
	logic [1:0] evVec;
	logic [1:0] clrVec;
	logic [1:0] next_intStatus;

	assign evVec[`RTCGT_RTC_EV_B] = rtcExpireEv;
	assign evVec[`RTCGT_GP_EV_B]  = gpExpireEv;
	assign clrVec = wrStat ? pwdata[1:0] : 2'h0;

	// Set beats clear so no expiry is lost
	// Status takes the registered expiry, so a bit
	// sets on the edge that its request output rises
	generate
		for (genvar i = 0; i < 2; i++) begin : g_stat
			assign next_intStatus[i] =
				evVec[i] || (intStatus[i] && !clrVec[i]);
		end
	endgenerate

	// Sticky status, mask and registered outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			intStatus <= `RTCGT_STAT_RST;
			intMask   <= `RTCGT_MASK_RST;
			irq       <= 1'b0;
			rtcExpire <= 1'b0;
			gpExpire  <= 1'b0;
		end else begin
			intStatus <= next_intStatus;
			if (wrMask) begin
				intMask <= pwdata[1:0];
			end
			irq       <= |(intStatus & intMask);
			// R15 pass one-cycle requests out
			rtcExpire <= rtcExpireEv;
			gpExpire  <= gpExpireEv;
		end
	end

	// ****************************************
	// Read path and handshake
	// ****************************************

	logic [31:0] rdMux;
	logic        rdErr;

	// Live values at shared addresses
	// Counters are sampled at the setup edge, so a
	// read returns one whole word from one cycle,
	// never a mix of old and new bits
	always_comb begin
		rdMux = 32'h0000_0000;
		rdErr = 1'b0;
		case (setupSel)
			// R1 live real-time counter
			SEL_RTC_CNT: rdMux = rtcCount;
			// R16 upper scaler bits zero
			SEL_RTC_SCL: rdMux = {24'h00_0000, rtcPrescale};
			SEL_GP_CNT:  rdMux = gpCount;
			SEL_GP_SCL:  rdMux = {16'h0000, gpPrescale};
			SEL_CTRL: begin
				rdMux[`RTCGT_GP_RELOAD_B]  = gpAutoReload;
				rdMux[`RTCGT_GP_RUN_B]     = gpRunEnable;
				rdMux[`RTCGT_RTC_RELOAD_B] = rtcAutoReload;
				rdMux[`RTCGT_RTC_RUN_B]    = rtcRunEnable;
			end
			SEL_STAT:    rdMux = {30'h0000_0000, intStatus};
			SEL_MASK:    rdMux = {30'h0000_0000, intMask};
			SEL_NONE:    rdErr = 1'b1;
			default:     rdErr = 1'b1;
		endcase
	end

	// No wait state: data captured at setup edge
	// Error rises only alongside ready
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setupPh;
			pslverr <= setupPh && rdErr;
			if (setupPh && !pwrite) begin
				prdata <= rdMux;
			end
		end
	end

endmodule : rtcgt_top

// ==== src/rtcgt_regs.svh ====
`ifndef RTCGT_REGS_SVH
`define RTCGT_REGS_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define RTCGT_RTC_CNT_OFS  32'h01F8_0080
`define RTCGT_RTC_SCL_OFS  32'h01F8_0084
`define RTCGT_GP_CNT_OFS   32'h01F8_0088
`define RTCGT_GP_SCL_OFS   32'h01F8_008C
`define RTCGT_CTRL_OFS     32'h01F8_0098
`define RTCGT_STAT_OFS     32'h01F8_00B0
`define RTCGT_MASK_OFS     32'h01F8_00B4

// ****************************************
// Widths
// ****************************************
`define RTCGT_CNT_W        32
`define RTCGT_RTC_SCL_W    8
`define RTCGT_GP_SCL_W     16

// ****************************************
// Reset values
// ****************************************
`define RTCGT_CNT_RST      32'hFFFF_FFFF
`define RTCGT_RTC_PRE_RST  32'h0FFF_FFFF
`define RTCGT_RTC_SCL_RST  8'hFF
`define RTCGT_GP_SCL_RST   16'hFFFF
`define RTCGT_STAT_RST     2'h0
`define RTCGT_MASK_RST     2'h0

// ****************************************
// Control register fields
// ****************************************
`define RTCGT_GP_RELOAD_B   0
`define RTCGT_GP_CLOAD_B    1
`define RTCGT_GP_RUN_B      2
`define RTCGT_GP_SLOAD_B    3
`define RTCGT_RTC_RELOAD_B  8
`define RTCGT_RTC_CLOAD_B   9
`define RTCGT_RTC_RUN_B     10
`define RTCGT_RTC_SLOAD_B   11

// ****************************************
// Status and mask fields
// ****************************************
`define RTCGT_RTC_EV_B     0
`define RTCGT_GP_EV_B      1

`endif

// ==== src/rtcgt_pkg.sv ====
`include "rtcgt_regs.svh"

package rtcgt_pkg;

	// ****************************************
	// Register selection
	// ****************************************
	typedef enum {
		SEL_NONE,
		SEL_RTC_CNT,
		SEL_RTC_SCL,
		SEL_GP_CNT,
		SEL_GP_SCL,
		SEL_CTRL,
		SEL_STAT,
		SEL_MASK
	} rtcgt_sel_t;

	typedef logic [31:0] rtcgt_word_t;

	// Address decode, shared by read and write paths
	function automatic rtcgt_sel_t rtcgt_decode(
		input rtcgt_word_t addr
	);
		case (addr)
			`RTCGT_RTC_CNT_OFS: rtcgt_decode = SEL_RTC_CNT;
			`RTCGT_RTC_SCL_OFS: rtcgt_decode = SEL_RTC_SCL;
			`RTCGT_GP_CNT_OFS:  rtcgt_decode = SEL_GP_CNT;
			`RTCGT_GP_SCL_OFS:  rtcgt_decode = SEL_GP_SCL;
			`RTCGT_CTRL_OFS:    rtcgt_decode = SEL_CTRL;
			`RTCGT_STAT_OFS:    rtcgt_decode = SEL_STAT;
			`RTCGT_MASK_OFS:    rtcgt_decode = SEL_MASK;
			default:            rtcgt_decode = SEL_NONE;
		endcase
	endfunction : rtcgt_decode

endpackage : rtcgt_pkg

// ==== src/rtcgt_timer.sv ====
`timescale 1ns/1ps
`include "rtcgt_regs.svh"

module rtcgt_timer
	import rtcgt_pkg::*;
#(
	parameter int SW = 8,
	parameter logic [SW-1:0] SCL_RST = '1
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst_n,
	// Control
	input  wire logic          runEnable,
	input  wire logic          autoReload,
	input  wire logic          countLoad,
	input  wire logic          prescaleLoad,
	input  wire logic [31:0]   countPreset,
	input  wire logic [SW-1:0] prescalePreset,
	// State
	output logic      [31:0]   count,
	output logic      [SW-1:0] prescale,
	output logic               expire
);

	// ****************************************
	// Underflow and expiry decode
	// ****************************************
	logic          running;
	wire logic     active    = runEnable && running;
	wire logic     sclZero   = (prescale == '0);
	wire logic     tick      = active && sclZero;
	// R5 expiry after preset periods
	// R10 same for second timer
	wire logic     lastTick  = tick && (count <= 32'h0000_0001);
	logic [31:0]   next_count;
	logic [SW-1:0] next_prescale;
	logic          next_running;

	// Scaler divides the clock by preset plus one
	always_comb begin
		next_prescale = prescale;
		if (prescaleLoad) begin
			next_prescale = prescalePreset;
		end else if (tick) begin
			next_prescale = prescalePreset;
		end else if (active) begin
			next_prescale = prescale - 1'b1;
		end
	end

	// Counter steps once per scaler underflow
	always_comb begin
		next_count   = count;
		next_running = running;
		if (countLoad) begin
			next_count   = countPreset;
			next_running = 1'b1;
		end else if (lastTick) begin
			// R11 reload or stop at zero
			next_count   = autoReload ? countPreset : '0;
			next_running = autoReload;
		end else if (tick) begin
			next_count = count - 32'h0000_0001;
		end
		if (prescaleLoad) begin
			next_running = 1'b1;
		end
	end

	// State registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count    <= `RTCGT_CNT_RST;
			prescale <= SCL_RST;
			running  <= 1'b1;
			expire   <= 1'b0;
		end else begin
			count    <= next_count;
			prescale <= next_prescale;
			running  <= next_running;
			// R15 one-cycle expiry pulse
			expire   <= lastTick && !countLoad;
		end
	end

endmodule : rtcgt_timer

// ==== tb/rtcgt_top_assertions.sv ====
`timescale 1ns/1ps
`include "rtcgt_regs.svh"

// ****************************************
// Bus answer and readback checks
// ****************************************
module rtcgt_top_check (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// APB slave
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Expiry and interrupt
	input wire logic        rtcExpire,
	input wire logic        gpExpire,
	input wire logic        irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Address lands on one of the mapped words
	wire logic mapped = paddr inside {`RTCGT_RTC_CNT_OFS,
		`RTCGT_RTC_SCL_OFS, `RTCGT_GP_CNT_OFS, `RTCGT_GP_SCL_OFS,
		`RTCGT_CTRL_OFS, `RTCGT_STAT_OFS, `RTCGT_MASK_OFS};

	// Bus phases
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence rd_s(a);
		pready && !pwrite && paddr == a;
	endsequence

	a_ready_setup: assert property (setup_s |=> pready)
		else $error("no answer after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("answer held too long");
	a_err_unmapped: assert property (pready && !mapped |-> pslverr)
		else $error("unmapped access not refused");
	a_err_mapped: assert property (pready && mapped |-> !pslverr)
		else $error("mapped access refused");
	a_rtc_scl_top: assert property (
		rd_s(`RTCGT_RTC_SCL_OFS) |-> prdata[31:8] == 24'h00_0000)
		else $error("rtc scaler upper bits set");
	a_gp_scl_top: assert property (
		rd_s(`RTCGT_GP_SCL_OFS) |-> prdata[31:16] == 16'h0000)
		else $error("gp scaler upper bits set");
	a_ctrl_loadbits: assert property (
		rd_s(`RTCGT_CTRL_OFS) |-> (prdata & 32'hFFFF_FAFA) == 0)
		else $error("control load bits read back");
	a_prdata_hold: assert property (
		!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved without a read");
endmodule : rtcgt_top_check

// ==== tb/rtc_and_general_timers_test.sv ====
`timescale 1ns/1ps
`include "rtcgt_regs.svh"

// ****************************************
// Timer block bench
// ****************************************
module rtc_and_general_timers_test
	import rtcgt_pkg::*;
;
	logic        clk, rst_n, psel, penable, pwrite, er;
	logic [31:0] paddr, pwdata, prdata;
	logic        pready, pslverr, rtcExpire, gpExpire, irq;
	logic [15:0] lfsr;
	rtcgt_word_t rd;
	int          badCount, checkCount, n;
	int          q[$];

	always #20 clk = ~clk;

	rtcgt_top i_rtcgt_top (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rtcExpire(rtcExpire),
		.gpExpire(gpExpire), .irq(irq));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			badCount++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; pready taken as sampled at the edge
	task automatic apb(input logic w, input logic [31:0] a, d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog ends a missing answer
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [31:0] a, d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdc(input logic [31:0] a, exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask : rdc

	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : nxt

	// Edges until the chosen expiry pulse, bounded
	task automatic wexp(input bit g);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((g ? gpExpire : rtcExpire) !== 1'b1 && n < 2000);
	endtask : wexp

	// Stop first so a stale pulse cannot shorten the count
	task automatic run(input bit g, input int c, input int s);
		wr(`RTCGT_CTRL_OFS, 32'h0000_0000);
		wr(g ? `RTCGT_GP_CNT_OFS : `RTCGT_RTC_CNT_OFS, c);
		wr(g ? `RTCGT_GP_SCL_OFS : `RTCGT_RTC_SCL_OFS, s);
		q.push_back(c * (s + 1));
		wr(`RTCGT_CTRL_OFS, g ? 32'h0000_000E : 32'h0000_0F00);
		wexp(g);
		chk(n, q[0] + 2);
		@(posedge clk);
		chk(g ? gpExpire : rtcExpire, 1'b0);
		if (g) begin
			rdc(`RTCGT_GP_CNT_OFS, 32'h0000_0000);
			rdc(`RTCGT_CTRL_OFS, 32'h0000_0004);
		end else begin
			wexp(1'b0);
			chk(n, q[0] - 1);
			rdc(`RTCGT_CTRL_OFS, 32'h0000_0500);
		end
		void'(q.pop_front());
	endtask : run

	task automatic stopTest;
		$display("checks %0d mismatches %0d", checkCount, badCount);
		if (badCount == 0 && checkCount > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stopTest

	// Hang guard, far beyond the expected run
	initial begin
		repeat (20000) @(posedge clk);
		badCount++;
		stopTest;
	end

	initial begin
		{clk, rst_n, psel, penable, pwrite} = 5'b00000;
		paddr = 32'h0000_0000;
		pwdata = 32'h0000_0000;
		{badCount, checkCount} = 0;
		lfsr = 16'h8DC6;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rdc(`RTCGT_RTC_CNT_OFS, 32'hFFFF_FFFF);
		rdc(`RTCGT_RTC_SCL_OFS, 32'h0000_00FF);
		rdc(`RTCGT_GP_CNT_OFS, 32'hFFFF_FFFF);
		rdc(`RTCGT_GP_SCL_OFS, 32'h0000_FFFF);
		rdc(`RTCGT_CTRL_OFS, 32'h0000_0100);
		$display("reset test done");
		wr(`RTCGT_RTC_CNT_OFS, 32'h0000_0005);
		wr(`RTCGT_GP_CNT_OFS, 32'h0000_0006);
		rdc(`RTCGT_RTC_CNT_OFS, 32'hFFFF_FFFF);
		rdc(`RTCGT_GP_CNT_OFS, 32'hFFFF_FFFF);
		wr(`RTCGT_RTC_SCL_OFS, 32'hFFFF_FF05);
		wr(`RTCGT_GP_SCL_OFS, 32'hFFFF_0007);
		wr(`RTCGT_CTRL_OFS, 32'h0000_0A0A);
		rdc(`RTCGT_RTC_SCL_OFS, 32'h0000_0005);
		rdc(`RTCGT_GP_SCL_OFS, 32'h0000_0007);
		rdc(`RTCGT_RTC_CNT_OFS, 32'h0000_0005);
		repeat (5) @(posedge clk);
		rdc(`RTCGT_GP_CNT_OFS, 32'h0000_0006);
		rdc(`RTCGT_CTRL_OFS, 32'h0000_0000);
		$display("preset test done");
		for (int i = 0; i < 4; i++) begin
			lfsr = nxt(lfsr);
			run(i[0], 2 + int'(lfsr[1:0]), int'(lfsr[3:2]));
		end
		$display("timer test done");
		wr(`RTCGT_CTRL_OFS, 32'h0000_0000);
		wr(`RTCGT_MASK_OFS, 32'h0000_0001);
		repeat (3) @(posedge clk);
		chk(irq, 1'b1);
		wr(`RTCGT_STAT_OFS, 32'h0000_0001);
		rdc(`RTCGT_STAT_OFS, 32'h0000_0002);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		wr(`RTCGT_MASK_OFS, 32'h0000_0002);
		repeat (3) @(posedge clk);
		chk(irq, 1'b1);
		wr(`RTCGT_STAT_OFS, 32'h0000_0002);
		rdc(`RTCGT_STAT_OFS, 32'h0000_0000);
		$display("interrupt test done");
		apb(1'b0, 32'h01F8_0090, 32'h0000_0000);
		chk(er, 1'b1);
		rdc(`RTCGT_MASK_OFS, 32'h0000_0002);
		chk(er, 1'b0);
		$display("bus test done");
		stopTest;
	end
endmodule : rtc_and_general_timers_test

bind rtcgt_top rtcgt_top_check i_rtcgt_top_check (.clk(clk),
	.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .rtcExpire(rtcExpire), .gpExpire(gpExpire),
	.irq(irq));
